/* File: src/adc_conversion_interface.sv */
/*
  conversion control of the sampling converter plus its result fifo.
  assumes all inputs synchronous to core_clk_in; the analog value arrives
  already quantised on analog_in in 0 dB code steps.
*/
// Operation
// - each result is a 14-bit two's complement word on the result pins.
// - up to 2.5 Msps; starts closer than one sample period are ignored.
// - two gain levels pick 0, -3, -6 or -9 dB.
// - out of range flag with result msb tells over or under range.
// - one start input and one ready indication form the whole handshake.
// - result and flag are valid when busy rises.
// - light and deep shutdown, entered regardless of conversion activity.
// - conversions timed by the internal clock count, no external clock.
// - a conversion starts on a falling edge of the start input while ready is high.
// - busy is low for the whole conversion, high when it ends.
// - low light input means light shutdown, low deep input deep shutdown.
// - msb low with flag high means input above the range.
`timescale 1ns/1ps
`default_nettype none
`include "adc_conv_defs.svh"

module adc_result_fifo #(
  parameter int unsigned WIDTH = 15,
  parameter int unsigned DEPTH = 8
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int unsigned PW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready_out = (cnt_q != CW'(DEPTH));
  assign out_valid_out = (cnt_q != '0);
  assign out_data_out = mem_q[rd_q];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  always_comb begin
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = in_data_in;
      wr_d = (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      mem_q <= mem_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end
endmodule : adc_result_fifo

module adc_conversion_interface #(
  parameter int unsigned DEEP_WAKE_CYC = `DEEP_WAKE_CYC
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic conv_start_n_in,
  input wire logic gain_sel_lo_in,
  input wire logic gain_sel_hi_in,
  input wire logic light_shutdown_n_in,
  input wire logic deep_shutdown_n_in,
  input wire adc_conv_pkg::analog_type analog_in,
  output logic busy_n_out,
  output logic conv_ready_out,
  output adc_conv_pkg::code_type result_bits_out,
  output logic out_of_range_flag_out,
  output logic light_shutdown_out,
  output logic deep_shutdown_out,
  output logic fifo_valid_out,
  input wire logic fifo_ready_in,
  output logic [`ADC_RES_W:0] fifo_data_out
);
  import adc_conv_pkg::*;

  // ------------------------------------------------------------
  // conversion state
  // ------------------------------------------------------------
  state_type state_q, state_d;
  logic start_n_q, start_n_d;
  logic [2:0] conv_cnt_q, conv_cnt_d;
  logic [2:0] gap_cnt_q, gap_cnt_d;
  logic [`WAKE_CNT_W-1:0] wake_cnt_q, wake_cnt_d;
  analog_type hold_q, hold_d;
  gain_type gain_q, gain_d;
  code_type result_q, result_d;
  logic otr_q, otr_d;
  logic push_d, push_q;
  logic fall, start_ok, start_acc, fifo_in_ready;
  logic [`ADC_RES_W:0] word;
  logic conv_done;

  assign fall = start_n_q & ~conv_start_n_in;
  assign start_ok = (state_q == ST_IDLE) && (gap_cnt_q == '0) && fifo_in_ready;
  assign start_acc = fall & start_ok & light_shutdown_n_in & deep_shutdown_n_in;
  assign conv_ready_out = start_ok;
  assign word = convert(hold_q, gain_q);
  // push at the ending edge so a start at the next edge sees the slot taken
  assign conv_done = (state_q == ST_CONV) && (conv_cnt_q == '0)
    && light_shutdown_n_in && deep_shutdown_n_in;

  always_comb begin
    state_d = state_q;
    start_n_d = conv_start_n_in;
    conv_cnt_d = conv_cnt_q;
    gap_cnt_d = (gap_cnt_q != '0) ? gap_cnt_q - 1'b1 : gap_cnt_q;
    wake_cnt_d = (wake_cnt_q != '0) ? wake_cnt_q - 1'b1 : wake_cnt_q;
    hold_d = hold_q;
    gain_d = gain_q;
    result_d = result_q;
    otr_d = otr_q;
    push_d = 1'b0;
    if (!deep_shutdown_n_in) begin
      state_d = ST_DEEP;
    end else if (!light_shutdown_n_in) begin
      state_d = ST_LIGHT;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start_acc) begin
            state_d = ST_CONV;
            hold_d = analog_in;
            gain_d = gain_type'({gain_sel_hi_in, gain_sel_lo_in});
            conv_cnt_d = 3'(`CONV_CYC - 1);
            gap_cnt_d = 3'(`SAMPLE_MIN_CYC - 1);
          end
        end
        ST_CONV: begin
          if (conv_cnt_q == '0) begin
            state_d = ST_IDLE;
            result_d = word[`ADC_RES_W-1:0];
            otr_d = word[`ADC_RES_W];
            push_d = 1'b1;
          end else begin
            conv_cnt_d = conv_cnt_q - 1'b1;
          end
        end
        ST_LIGHT: begin
          state_d = ST_WAKE;
          wake_cnt_d = `WAKE_CNT_W'(`LIGHT_WAKE_CYC - 1);
        end
        ST_DEEP: begin
          state_d = ST_WAKE;
          wake_cnt_d = `WAKE_CNT_W'(DEEP_WAKE_CYC - 1);
        end
        ST_WAKE: begin
          if (wake_cnt_q == '0) begin
            state_d = ST_IDLE;
          end
        end
        default: state_d = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q <= ST_IDLE;
      start_n_q <= 1'b1;
      conv_cnt_q <= '0;
      gap_cnt_q <= '0;
      wake_cnt_q <= '0;
      hold_q <= '0;
      gain_q <= GAIN_0DB;
      result_q <= '0;
      otr_q <= 1'b0;
      push_q <= 1'b0;
    end else begin
      state_q <= state_d;
      start_n_q <= start_n_d;
      conv_cnt_q <= conv_cnt_d;
      gap_cnt_q <= gap_cnt_d;
      wake_cnt_q <= wake_cnt_d;
      hold_q <= hold_d;
      gain_q <= gain_d;
      result_q <= result_d;
      otr_q <= otr_d;
      push_q <= push_d;
    end
  end

  assign busy_n_out = (state_q != ST_CONV);
  assign result_bits_out = result_q;
  assign out_of_range_flag_out = otr_q;
  assign light_shutdown_out = (state_q == ST_LIGHT);
  assign deep_shutdown_out = (state_q == ST_DEEP);

  // ------------------------------------------------------------
  // result buffer
  // ------------------------------------------------------------
  adc_result_fifo #(
    .WIDTH(`ADC_RES_W + 1),
    .DEPTH(`FIFO_DEPTH)
  ) u_fifo (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .in_valid_in(conv_done),
    .in_ready_out(fifo_in_ready),
    .in_data_in(word),
    .out_valid_out(fifo_valid_out),
    .out_ready_in(fifo_ready_in),
    .out_data_out(fifo_data_out)
  );

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_start;
    start_acc;
  endsequence

  sequence s_conv_body;
    !busy_n_out [*3] ##1 busy_n_out;
  endsequence

  a_busy_conv_len: assert property (
    @(posedge core_clk_in) disable iff (reset_in || !light_shutdown_n_in || !deep_shutdown_n_in)
    s_start |=> s_conv_body)
    else $error("busy low time wrong");

  a_result_at_busy: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    $rose(busy_n_out) && push_q |-> {out_of_range_flag_out, result_bits_out} == $past(word))
    else $error("result not valid at busy rise");

  a_over_range: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    $rose(push_q) && otr_q && !result_q[`ADC_RES_W-1] |-> $past(hold_q) > 0)
    else $error("over range flagged for low input");

  a_start_spacing: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    s_start |=> !start_acc [*3])
    else $error("starts closer than one sample period");

  a_start_edge: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    start_acc |-> ($past(conv_start_n_in) || $past(reset_in)) && !conv_start_n_in)
    else $error("start taken without falling edge");

  a_gain_latched: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    s_start |=> gain_q == gain_type'({$past(gain_sel_hi_in), $past(gain_sel_lo_in)}))
    else $error("gain not latched at start");

  a_shutdown_enter: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    !deep_shutdown_n_in |=> deep_shutdown_out && busy_n_out)
    else $error("deep shutdown not entered");

  a_light_wake: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    light_shutdown_out && deep_shutdown_n_in && light_shutdown_n_in
      ##1 (deep_shutdown_n_in && light_shutdown_n_in) [*2] |-> !conv_ready_out)
    else $error("start allowed during light wake");

  a_result_kept: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    conv_done |-> fifo_in_ready)
    else $error("finished result dropped by full buffer");
endmodule : adc_conversion_interface

`default_nettype wire

/* File: inc/adc_conv_defs.svh */
/*
  timing counts, widths and fifo sizing for the conversion interface.
  assumes a 10 MHz core clock; every count is derived from printed times.
*/
`ifndef ADC_CONV_DEFS_SVH
`define ADC_CONV_DEFS_SVH

`define ADC_RES_W 14
`define ANALOG_W 16
`define CLK_PERIOD_NS 100
`define CONV_MAX_NS 350
`define CONV_CYC (`CONV_MAX_NS / `CLK_PERIOD_NS)
`define SAMPLE_RATE_KSPS 2500
`define SAMPLE_PERIOD_NS (1000000 / `SAMPLE_RATE_KSPS)
`define SAMPLE_MIN_CYC ((`SAMPLE_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LIGHT_WAKE_NS 200
`define LIGHT_WAKE_CYC ((`LIGHT_WAKE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DEEP_WAKE_MS 10
`define DEEP_WAKE_CYC ((`DEEP_WAKE_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_CNT_W 24
`define FIFO_DEPTH 8
`define GAIN_MUL_0DB 10'h080
`define GAIN_MUL_3DB 10'h0b5
`define GAIN_MUL_6DB 10'h100
`define GAIN_MUL_9DB 10'h16a
`define GAIN_SHIFT 7

`endif

/* File: inc/adc_conv_pkg.sv */
/*
  types and the shared conversion function of the conversion interface.
  assumes adc_conv_defs.svh is on the include path.
*/
`include "adc_conv_defs.svh"

package adc_conv_pkg;

  typedef enum logic [1:0] {
    GAIN_M9DB = 2'h0,
    GAIN_M3DB = 2'h1,
    GAIN_M6DB = 2'h2,
    GAIN_0DB = 2'h3
  } gain_type;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CONV,
    ST_LIGHT,
    ST_DEEP,
    ST_WAKE
  } state_type;

  typedef logic [`ADC_RES_W-1:0] code_type;
  typedef logic signed [`ANALOG_W-1:0] analog_type;

  // scale by gain, saturate, return {out of range, two's complement code}
  function automatic logic [`ADC_RES_W:0] convert(input analog_type a, input gain_type g);
    logic signed [`ANALOG_W+11:0] prod;
    logic signed [`ANALOG_W+11:0] lim_hi;
    logic signed [`ANALOG_W+11:0] lim_lo;
    logic [9:0] mul;
    mul = `GAIN_MUL_0DB;
    case (g)
      GAIN_M3DB: mul = `GAIN_MUL_3DB;
      GAIN_M6DB: mul = `GAIN_MUL_6DB;
      GAIN_M9DB: mul = `GAIN_MUL_9DB;
      default: mul = `GAIN_MUL_0DB;
    endcase
    prod = (a * $signed({2'h0, mul})) >>> `GAIN_SHIFT;
    lim_hi = (`ANALOG_W+12)'(2 ** (`ADC_RES_W - 1) - 1);
    lim_lo = -(`ANALOG_W+12)'(2 ** (`ADC_RES_W - 1));
    if (prod > lim_hi) begin
      convert = {1'b1, 1'b0, {(`ADC_RES_W-1){1'b1}}};
    end else if (prod < lim_lo) begin
      convert = {1'b1, 1'b1, {(`ADC_RES_W-1){1'b0}}};
    end else begin
      convert = {1'b0, prod[`ADC_RES_W-1:0]};
    end
  endfunction : convert

endpackage : adc_conv_pkg

/* File: tb/fifo_sink_model.sv */
/*
  sink model for the result fifo output, standing in for the host side.
  assumes one clock shared with the converter; the bench commands stalls.
*/
`timescale 1ns/1ps
`default_nettype none
module fifo_sink_model (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic stall_in,
  output logic ready_out
);
  // takes the head word whenever the bench did not stall it the cycle before
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ready_out <= 1'b0;
    end else begin
      ready_out <= !stall_in;
    end
  end
endmodule : fifo_sink_model
`default_nettype wire

/* File: tb/adc_conversion_interface_test.sv */
/*
  self-checking bench for the conversion interface and its result fifo.
  assumes the package is compiled first; bench acts as the start host.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_interface_test;
  import adc_conv_pkg::*;
  logic clk = 0, rst = 1, start_n = 1, glo = 1, ghi = 1, lt_n = 1, dp_n = 1, stall = 0;
  analog_type ana = '0;
  logic busy_n, rdy, out_of_range_flag, lt_o, dp_o, fv, fr;
  code_type res;
  logic [14:0] fd;
  int failures = 0, checked = 0, seed = 82442, n;
  logic [14:0] q[$];
  adc_conversion_interface #(.DEEP_WAKE_CYC(20)) dut_u (.core_clk_in(clk), .reset_in(rst),
    .conv_start_n_in(start_n), .gain_sel_lo_in(glo), .gain_sel_hi_in(ghi),
    .light_shutdown_n_in(lt_n), .deep_shutdown_n_in(dp_n), .analog_in(ana),
    .busy_n_out(busy_n), .conv_ready_out(rdy), .result_bits_out(res),
    .out_of_range_flag_out(out_of_range_flag), .light_shutdown_out(lt_o), .deep_shutdown_out(dp_o),
    .fifo_valid_out(fv), .fifo_ready_in(fr), .fifo_data_out(fd));
  fifo_sink_model sink_u (.core_clk_in(clk), .reset_in(rst), .stall_in(stall), .ready_out(fr));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  function logic [14:0] expect_word(input analog_type a, input logic [1:0] g);
    logic signed [27:0] p;
    int m;
    m = (g == 2'h3) ? 128 : (g == 2'h1) ? 181 : (g == 2'h2) ? 256 : 362;
    p = (28'(a) * 28'(m)) >>> 7;
    if (p > 8191) return {1'b1, 14'h1fff};
    if (p < -8192) return {1'b1, 14'h2000};
    return {1'b0, p[13:0]};
  endfunction : expect_word
  task conv(input analog_type a, input logic [1:0] g, input bit poke);
    @(posedge clk) start_n <= 0;
    ana <= a;
    {ghi, glo} <= g;
    #1 chk(rdy, 1);
    @(posedge clk) start_n <= 1;
    for (int i = 0; i < 3; i++) begin
      if (poke && i > 0) start_n <= (i == 2);
      #1 chk(busy_n, 0);
      if (i < 2) @(posedge clk);
    end
    @(posedge clk) #1 chk(busy_n, 1);
    chk({out_of_range_flag, res}, expect_word(a, g));
    q.push_back(expect_word(a, g));
    if (poke) repeat (3) @(posedge clk) #1 chk(busy_n, 1);
  endtask : conv
  task try_refused();
    @(posedge clk) start_n <= 0;
    #1 chk(rdy, 0);
    @(posedge clk) start_n <= 1;
    repeat (4) @(posedge clk) #1 chk(busy_n, 1);
  endtask : try_refused
  task wait_ready(input int lo);
    n = 0;
    do begin
      @(posedge clk) #1 n++;
    end while (rdy !== 1'b1 && n < 100);
    chk(n >= lo && n < 100, 1);
  endtask : wait_ready
  task shut(input bit deep);
    @(posedge clk) if (deep) dp_n <= 0; else lt_n <= 0;
    @(posedge clk);
    @(posedge clk) #1 chk({dp_o, lt_o, busy_n}, {deep, !deep, 1'b1});
    @(posedge clk) dp_n <= 1;
    lt_n <= 1;
    wait_ready(deep ? 20 : 2);
  endtask : shut
  task tally_and_finish();
    $display("failures=%0d checked=%0d", failures, checked);
    if (failures == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------
  // clock, monitor, watchdog
  // ----------------------------------------
  initial begin
    forever #50 clk = !clk;
  end
  always @(posedge clk) begin
    if (fv === 1'b1 && fr === 1'b1) begin
      if (q.size() == 0) chk(fd, 16'hffff);
      else chk(fd, q.pop_front());
    end
  end
  initial begin
    #(100 * 6000);
    failures++;
    tally_and_finish();
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rst <= 0;
    #1 chk({busy_n, rdy, fv, out_of_range_flag, lt_o, dp_o}, 6'b110000);
    chk(res, 14'h0);
    for (int g = 0; g < 4; g++) begin
      conv(16'sh7fff, 2'(g), g == 0);
      conv(16'sh8000, 2'(g), 0);
      conv(16'sh0000, 2'(g), 0);
    end
    for (int i = 0; i < 12; i++) conv(16'($random(seed) % 12000), 2'($random(seed)), 0);
    repeat (8) @(posedge clk);
    stall <= 1;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 8; i++) conv(16'($random(seed)), 2'($random(seed)), 0);
    try_refused();
    stall <= 0;
    repeat (12) @(posedge clk);
    shut(0);
    shut(1);
    @(posedge clk) start_n <= 0;
    @(posedge clk) start_n <= 1;
    @(posedge clk) dp_n <= 0;
    @(posedge clk) dp_n <= 1;
    wait_ready(20);
    conv(-16'sd1000, 2'h1, 0);
    repeat (6) @(posedge clk);
    chk({fv, 15'(q.size())}, 16'h0);
    tally_and_finish();
  end
endmodule : adc_conversion_interface_test
`default_nettype wire
